// file: hdl/switch_cfg_pkg.sv
// Purpose: Shared constants and types of the serial configuration block
// Assumes: 16-bit frames, two output switches
// Notes: Addresses are the five frame bits 14:10
package switch_cfg_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 8;
    localparam int WD_POS = 15;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 10;
    localparam int SEL_POS = 13;
    localparam int DATA_W = 9;
    localparam int SOA_W = 5;
    localparam int NM_POS = 9;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_STATUS_LO = 3'h0;
    localparam logic [2:0] ADDR_FAULT_LO = 3'h3;
    localparam logic [2:0] ADDR_OC_LO = 3'h4;
    localparam logic [4:0] ADDR_GLOBAL = 5'h05;
    localparam logic [4:0] ADDR_CALIB = 5'h07;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int F_RETRY_UNLIM = 6;
    localparam int F_RETRY_OFF = 5;
    localparam int F_SHORT_OFF = 4;
    localparam int F_ON_OL_OFF = 3;
    localparam int F_OFF_OL_OFF = 2;
    localparam int F_OL_LED = 1;
    localparam int F_RATIO = 0;
    localparam int O_LAMP = 8;
    localparam int O_HI_INRUSH = 3;
    localparam int O_MODE = 0;
    localparam int G_FAIL_EN = 8;
    localparam int G_PWM_EN = 7;
    localparam int G_CLK_SEL = 6;
    localparam int G_TEMP_EN = 5;
    localparam int G_CUR_EN = 4;
    localparam int G_OV_OFF = 0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [8:0] CFG_RESET = 9'h000;
    localparam logic [4:0] SOA_RESET = 5'h00;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SPD_SLOW, SPD_MEDIUM, SPD_FAST, SPD_VSLOW} speed_t;
    typedef enum logic [1:0] {LIM_1, LIM_2, LIM_3, LIM_4} limit_t;
    typedef enum logic [1:0] {SENSE_OFF, SENSE_CUR_HS0, SENSE_CUR_HS1, SENSE_TEMP} sense_t;
endpackage

// file: hdl/dual_switch_serial_config_regs.sv
// Purpose: Serial frame handling and configuration registers of a dual switch
// Assumes: Link clock idles low, bits taken on its rising edge
// Notes: Link data is read by clk only after the frame has ended
//
// Contract
// - Unlimited-retry bit set stops the retry counter for that output.
// - Retry-disable bit set means no auto-retry for that output.
// - Short-to-supply disable bit turns off that protection per output.
// - On-state open load off if disabled, else bulb or LED threshold.
// - Off-state open-load disable bit stops off-state detection per output.
// - Sense ratio bit selects high ratio when one, low when zero.
// - Discharge-lamp bit switches output to the discharge-lamp overcurrent profile.
// - Cooling field: 00 medium, 01 slow, 10 fast, 11 medium.
// - Inrush field: 00 slow, 01 fast, 10 medium, 11 very slow.
// - High-inrush bit selects second high level during first interval.
// - Steady field: 00 level two, 01 three, 10 four, 11 one.
// - Mode bit: zero inrush only, one inrush plus cooling.
// - Fail enable plus logic supply failure keeps outputs on pulse register.
// - Pulse module enable drives outputs from pulse register, ignores pins.
// - Clock select picks external or internal clock only when enabled.
// - Sense pin off, output current by select code, or temperature.
// - Overvoltage-disable bit set turns overvoltage protection off.
// - Chip select fall loads return word, shifted out MSB first.
// - After sixteen bits, serial out repeats input delayed sixteen clocks.
// - Chip select rise latches only multiple-of-16 frames, tristates, re-arms.
// - Returned low bits follow the latest status-select write until changed.
// - Invalid-length transfer leaves reported status as if it never happened.
// - Frame: watchdog top, address 14 and 12:10, select 13, data 8:0.
// - Return word: previous watchdog, previous select code, normal flag one.
// - Configuration bits clear on reset or logic supply failure; supply failure keeps the fail enable bit.
module dual_switch_serial_config_regs
    import switch_cfg_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic reset,
    // Serial link
    input wire logic link_clk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // Device state
    input wire logic supply_fail_pin,
    input wire logic [switch_cfg_pkg::DATA_W-1:0] fault_status_0,
    input wire logic [switch_cfg_pkg::DATA_W-1:0] fault_status_1,
    output logic fault_rearm,
    // Per-output fault settings
    output logic [1:0] retry_unlimited,
    output logic [1:0] retry_off,
    output logic [1:0] supply_short_prot_off,
    output logic [1:0] on_openload_en,
    output logic [1:0] on_openload_led_thresh,
    output logic [1:0] off_openload_en,
    output logic [1:0] sense_ratio_high,
    // Per-output overcurrent settings
    output logic [1:0] discharge_lamp_profile,
    output switch_cfg_pkg::speed_t [1:0] cooling_speed,
    output switch_cfg_pkg::speed_t [1:0] inrush_speed,
    output logic [1:0] high_inrush_level_sel,
    output switch_cfg_pkg::limit_t [1:0] steady_limit,
    output logic [1:0] overcurrent_mode_sel,
    // Global settings
    output logic failsafe_pwm_drive,
    output logic pwm_drive_outputs,
    output logic pwm_clk_external,
    output logic pwm_clk_internal,
    output switch_cfg_pkg::sense_t analog_sense_mode,
    output logic overvoltage_prot_off,
    output logic [switch_cfg_pkg::DATA_W-1:0] clock_calibration_value
);
    import switch_cfg_pkg::*;

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic speed_t cooling_map(input logic [1:0] c);
        case (c)
            2'h1: cooling_map = SPD_SLOW;
            2'h2: cooling_map = SPD_FAST;
            default: cooling_map = SPD_MEDIUM;
        endcase
    endfunction

    function automatic speed_t inrush_map(input logic [1:0] c);
        case (c)
            2'h1: inrush_map = SPD_FAST;
            2'h2: inrush_map = SPD_MEDIUM;
            2'h3: inrush_map = SPD_VSLOW;
            default: inrush_map = SPD_SLOW;
        endcase
    endfunction

    function automatic limit_t limit_map(input logic [1:0] c);
        case (c)
            2'h1: limit_map = LIM_3;
            2'h2: limit_map = LIM_4;
            2'h3: limit_map = LIM_1;
            default: limit_map = LIM_2;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    logic [FRAME_BITS-1:0] rx_shift_reg;
    logic [FRAME_BITS-1:0] tx_shift_reg;
    logic [CNT_W-1:0] bit_count_reg;
    logic rx_started_reg;
    logic tx_started_reg;
    logic [FRAME_BITS-1:0] status_word_reg;

    always_ff @(posedge link_clk) begin
        rx_shift_reg <= {rx_shift_reg[FRAME_BITS-2:0], serial_in};
    end

    // Frame flags cleared by the frame's own select
    always_ff @(posedge link_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            rx_started_reg <= 1'b0;
        end else begin
            rx_started_reg <= 1'b1;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!rx_started_reg) begin
            bit_count_reg <= CNT_W'(1);
        end else begin
            bit_count_reg <= bit_count_reg + CNT_W'(1);
        end
    end

    always_ff @(negedge link_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            tx_started_reg <= 1'b0;
        end else begin
            tx_started_reg <= 1'b1;
        end
    end

    // Return word first, then the input stream sixteen bits late
    always_ff @(negedge link_clk) begin
        if (!tx_started_reg) begin
            tx_shift_reg <= {status_word_reg[FRAME_BITS-2:0], rx_shift_reg[0]};
        end else begin
            tx_shift_reg <= {tx_shift_reg[FRAME_BITS-2:0], rx_shift_reg[0]};
        end
    end

    assign serial_out = tx_started_reg ? tx_shift_reg[FRAME_BITS-1] :
        status_word_reg[FRAME_BITS-1];
    assign serial_out_oe = ~chip_select_n;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic fail_s1_reg;
    logic fail_s2_reg;

    always_ff @(posedge clk) begin
        cs_s1_reg <= chip_select_n;
        cs_s2_reg <= cs_s1_reg;
        cs_s3_reg <= cs_s2_reg;
        fail_s1_reg <= supply_fail_pin;
        fail_s2_reg <= fail_s1_reg;
    end

    // ------------------------------------------------------------
    // Frame commit
    // ------------------------------------------------------------
    wire cs_rise = cs_s2_reg & ~cs_s3_reg;
    wire len_ok = (bit_count_reg[3:0] == 4'h0) && (bit_count_reg != '0);
    wire commit = cs_rise & len_ok;
    wire [4:0] frame_addr = rx_shift_reg[ADDR_HI:ADDR_LO];
    wire frame_sel = rx_shift_reg[SEL_POS];
    wire [DATA_W-1:0] frame_data = rx_shift_reg[DATA_W-1:0];
    wire per_out = frame_addr[4];
    wire wr_status = commit && (frame_addr[2:0] == ADDR_STATUS_LO);
    wire wr_fault = commit && per_out && (frame_addr[2:0] == ADDR_FAULT_LO);
    wire wr_oc = commit && per_out && (frame_addr[2:0] == ADDR_OC_LO);
    wire wr_global = commit && (frame_addr == ADDR_GLOBAL);
    wire wr_calib = commit && (frame_addr == ADDR_CALIB);

    logic [DATA_W-1:0] fault_cfg_reg [2];
    logic [DATA_W-1:0] oc_cfg_reg [2];
    logic [DATA_W-1:0] global_config_reg;
    logic [DATA_W-1:0] clock_calibration_reg;
    logic [SOA_W-1:0] status_select_reg;
    logic prev_wd_reg;
    logic fault_rearm_reg;
    wire supply_clear = fail_s2_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            global_config_reg <= CFG_RESET;
            clock_calibration_reg <= CFG_RESET;
        end else if (supply_clear) begin
            global_config_reg <= CFG_RESET | (global_config_reg & (9'h001 << G_FAIL_EN));
            clock_calibration_reg <= CFG_RESET;
        end else begin
            if (wr_global) begin
                global_config_reg <= frame_data;
            end
            if (wr_calib) begin
                clock_calibration_reg <= frame_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status_select_reg <= SOA_RESET;
            prev_wd_reg <= 1'b0;
            fault_rearm_reg <= 1'b0;
        end else begin
            fault_rearm_reg <= cs_rise;
            if (commit) begin
                prev_wd_reg <= rx_shift_reg[WD_POS];
            end
            if (wr_status) begin
                status_select_reg <= rx_shift_reg[SOA_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Per-output registers and decoding
    // ------------------------------------------------------------
    logic [1:0] ol_on_en_reg;
    logic [1:0] ol_off_en_reg;
    speed_t [1:0] cooling_reg;
    speed_t [1:0] inrush_reg;
    limit_t [1:0] limit_reg;
    logic [1:0] retry_unlim_reg;
    logic [1:0] retry_off_reg;
    logic [1:0] short_off_reg;
    logic [1:0] led_reg;
    logic [1:0] ratio_reg;
    logic [1:0] lamp_reg;
    logic [1:0] hi_inrush_reg;
    logic [1:0] mode_reg;

    for (genvar i = 0; i < 2; i++) begin : g_out
        wire [DATA_W-1:0] f = fault_cfg_reg[i];
        wire [DATA_W-1:0] o = oc_cfg_reg[i];
        wire [DATA_W-1:0] f_next = (wr_fault && frame_sel == 1'(i)) ? frame_data : f;
        wire [DATA_W-1:0] o_next = (wr_oc && frame_sel == 1'(i)) ? frame_data : o;
        always_ff @(posedge clk) begin
            if (reset || supply_clear) begin
                fault_cfg_reg[i] <= CFG_RESET;
                oc_cfg_reg[i] <= CFG_RESET;
            end else begin
                fault_cfg_reg[i] <= f_next;
                oc_cfg_reg[i] <= o_next;
            end
        end
        always_ff @(posedge clk) begin
            retry_unlim_reg[i] <= f[F_RETRY_UNLIM];
            retry_off_reg[i] <= f[F_RETRY_OFF];
            short_off_reg[i] <= f[F_SHORT_OFF];
            ol_on_en_reg[i] <= ~f[F_ON_OL_OFF];
            led_reg[i] <= ~f[F_ON_OL_OFF] & f[F_OL_LED];
            ol_off_en_reg[i] <= ~f[F_OFF_OL_OFF];
            ratio_reg[i] <= f[F_RATIO];
            lamp_reg[i] <= o[O_LAMP];
            cooling_reg[i] <= cooling_map(o[7:6]);
            inrush_reg[i] <= inrush_map(o[5:4]);
            hi_inrush_reg[i] <= o[O_HI_INRUSH];
            limit_reg[i] <= limit_map(o[2:1]);
            mode_reg[i] <= o[O_MODE];
        end
    end

    assign retry_unlimited = retry_unlim_reg;
    assign retry_off = retry_off_reg;
    assign supply_short_prot_off = short_off_reg;
    assign on_openload_en = ol_on_en_reg;
    assign on_openload_led_thresh = led_reg;
    assign off_openload_en = ol_off_en_reg;
    assign sense_ratio_high = ratio_reg;
    assign discharge_lamp_profile = lamp_reg;
    assign cooling_speed = cooling_reg;
    assign inrush_speed = inrush_reg;
    assign high_inrush_level_sel = hi_inrush_reg;
    assign steady_limit = limit_reg;
    assign overcurrent_mode_sel = mode_reg;

    // ------------------------------------------------------------
    // Global decoding
    // ------------------------------------------------------------
    wire [DATA_W-1:0] g = global_config_reg;
    wire cur_hs0 = g[G_CUR_EN] && (g[3:2] == 2'h2);
    wire cur_hs1 = g[G_CUR_EN] && (g[3:2] == 2'h3);
    wire sense_t sense_next = cur_hs0 ? SENSE_CUR_HS0 : cur_hs1 ? SENSE_CUR_HS1 :
        g[G_TEMP_EN] ? SENSE_TEMP : SENSE_OFF;
    logic failsafe_reg;
    logic pwm_drive_reg;
    logic clk_ext_reg;
    logic clk_int_reg;
    sense_t sense_reg;
    logic ov_off_reg;
    logic [DATA_W-1:0] calib_out_reg;

    always_ff @(posedge clk) begin
        failsafe_reg <= g[G_FAIL_EN] & fail_s2_reg;
        pwm_drive_reg <= g[G_PWM_EN];
        clk_ext_reg <= g[G_PWM_EN] & ~g[G_CLK_SEL];
        clk_int_reg <= g[G_PWM_EN] & g[G_CLK_SEL];
        sense_reg <= sense_next;
        ov_off_reg <= g[G_OV_OFF];
        calib_out_reg <= clock_calibration_reg;
    end

    assign failsafe_pwm_drive = failsafe_reg;
    assign pwm_drive_outputs = pwm_drive_reg;
    assign pwm_clk_external = clk_ext_reg;
    assign pwm_clk_internal = clk_int_reg;
    assign analog_sense_mode = sense_reg;
    assign overvoltage_prot_off = ov_off_reg;
    assign clock_calibration_value = calib_out_reg;
    assign fault_rearm = fault_rearm_reg;

    // ------------------------------------------------------------
    // Return word, frozen while a frame runs
    // ------------------------------------------------------------
    wire [2:0] soa_lo = status_select_reg[2:0];
    wire soa_out = status_select_reg[3];
    wire [DATA_W-1:0] ret_data =
        (status_select_reg == ADDR_GLOBAL) ? global_config_reg :
        (status_select_reg == ADDR_CALIB) ? clock_calibration_reg :
        (status_select_reg[4] && soa_lo == ADDR_FAULT_LO) ? fault_cfg_reg[soa_out] :
        (status_select_reg[4] && soa_lo == ADDR_OC_LO) ? oc_cfg_reg[soa_out] :
        (status_select_reg[4] && soa_lo == ADDR_STATUS_LO) ?
        (soa_out ? fault_status_1 : fault_status_0) : '0;

    always_ff @(posedge clk) begin
        if (reset) begin
            status_word_reg <= '0;
        end else if (cs_s2_reg && !cs_rise) begin
            status_word_reg <= {prev_wd_reg, status_select_reg, 1'b1, ret_data};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_valid_frame;
        cs_rise && len_ok;
    endsequence

    sequence s_global_written;
        s_valid_frame ##0 (frame_addr == ADDR_GLOBAL);
    endsequence

    a_invalid_ignored: assert property (cs_rise && !len_ok && !supply_clear |=>
        $stable(global_config_reg) && $stable(status_select_reg))
        else $error("invalid frame changed registers");
    a_global_latch: assert property (s_global_written ##0 !supply_clear |=>
        global_config_reg == $past(frame_data))
        else $error("global register not latched");
    a_pwm_path: assert property (s_global_written ##0 !supply_clear ##2 1 |->
        pwm_drive_outputs == $past(frame_data[G_PWM_EN], 2))
        else $error("pulse enable not applied");
    a_clk_select: assert property ((pwm_clk_internal || pwm_clk_external) |->
        pwm_drive_outputs && !(pwm_clk_internal && pwm_clk_external))
        else $error("clock select without module enable");
    a_rearm_pulse: assert property (cs_rise |=> fault_rearm ##1 !fault_rearm)
        else $error("re-arm pulse wrong");
    a_normal_flag: assert property (!$past(reset) |-> status_word_reg[NM_POS])
        else $error("normal flag missing");
    a_openload_off: assert property (##1 $past(fault_cfg_reg[0][F_ON_OL_OFF]) |->
        !on_openload_en[0] && !on_openload_led_thresh[0])
        else $error("on-state open load not disabled");
    a_sense_temp: assert property (g[G_TEMP_EN] && !g[G_CUR_EN] |=>
        analog_sense_mode == SENSE_TEMP)
        else $error("temperature feedback not selected");
    a_reset_clear: assert property ($past(supply_clear) |->
        fault_cfg_reg[1] == CFG_RESET && oc_cfg_reg[0] == CFG_RESET)
        else $error("configuration not cleared");
    a_word_frozen: assert property (!cs_s2_reg ##1 !cs_s2_reg |->
        $stable(status_word_reg))
        else $error("return word moved during frame");
endmodule

// file: tb/spi_host_model.sv
// Purpose: Host side of the serial link, master of frames
// Assumes: Link clock idles low, 30 ns period, stopped between frames
// Notes: Data in is inverted once released so a stale level never passes
module spi_host_model (
    // Link
    output logic link_clk,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_clk = 1'b0;
        serial_in = 1'b0;
        // Edge at start clears the frame flags
        chip_select_n = 1'b0;
        #1 chip_select_n = 1'b1;
    end
    // Frame of n bits, MSB first; return bits taken at each rising edge
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        #1 chip_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = tx[i];
            #15 link_clk = 1'b1;
            rx = {rx[30:0], serial_out};
            #15 link_clk = 1'b0;
        end
        #15 chip_select_n = 1'b1;
        serial_in = ~serial_in;
        #120;
    endtask
endmodule

// file: tb/dual_switch_serial_config_regs_tb.sv
// Purpose: Self-checking bench of the serial configuration block
// Assumes: Host model drives the link; status inputs held at fixed patterns
// Notes: Scenarios run in order and build on earlier register contents
module dual_switch_serial_config_regs_tb;
    import switch_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, reset = 1'b1, supply_fail_pin = 1'b0;
    logic link_clk, chip_select_n, serial_in, serial_out, serial_out_oe, fault_rearm;
    logic [1:0] retry_unlimited, retry_off, supply_short_prot_off, on_openload_en;
    logic [1:0] on_openload_led_thresh, off_openload_en, sense_ratio_high;
    logic [1:0] discharge_lamp_profile, high_inrush_level_sel, overcurrent_mode_sel;
    speed_t [1:0] cooling_speed, inrush_speed;
    limit_t [1:0] steady_limit;
    sense_t analog_sense_mode;
    logic failsafe_pwm_drive, pwm_drive_outputs, pwm_clk_external, pwm_clk_internal;
    logic overvoltage_prot_off;
    logic [8:0] clock_calibration_value;
    int n_mismatch = 0, cmp_count = 0, n_rearm = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (fault_rearm === 1'b1) begin
            n_rearm++;
        end
    end
    spi_host_model spi_host_model_inst (.link_clk(link_clk), .chip_select_n(chip_select_n),
        .serial_in(serial_in), .serial_out(serial_out));
    dual_switch_serial_config_regs dual_switch_serial_config_regs_inst (.*,
        .fault_status_0(9'h0a5), .fault_status_1(9'h15a));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic wd, input logic [4:0] a, input logic [8:0] d);
        logic [31:0] r;
        spi_host_model_inst.xfer(16, {16'h0000, wd, a, 1'b0, d}, r);
        check("oe", 32'(serial_out_oe), 32'h0);
        repeat (8) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("on_ol", 32'(on_openload_en), 32'h3);
        check("off_ol", 32'(off_openload_en), 32'h3);
        check("cool", 32'(cooling_speed[0]), 32'(SPD_MEDIUM));
        check("limit", 32'(steady_limit[1]), 32'(LIM_2));
        check("sense", 32'(analog_sense_mode), 32'(SENSE_OFF));
        $display("test reset done");
    endtask
    task automatic t_fault;
        wr(0, 5'b10011, 9'h07f);
        wr(1, 5'b11011, 9'h002);
        check("unlim", 32'(retry_unlimited), 32'h1);
        check("rtyoff", 32'(retry_off), 32'h1);
        check("short", 32'(supply_short_prot_off), 32'h1);
        check("on_ol", 32'(on_openload_en), 32'h2);
        check("led", 32'(on_openload_led_thresh), 32'h2);
        check("off_ol", 32'(off_openload_en), 32'h2);
        check("ratio", 32'(sense_ratio_high), 32'h1);
        $display("test fault config done");
    endtask
    task automatic t_oc;
        speed_t ce[4] = '{SPD_MEDIUM, SPD_SLOW, SPD_FAST, SPD_MEDIUM};
        speed_t ie[4] = '{SPD_SLOW, SPD_FAST, SPD_MEDIUM, SPD_VSLOW};
        limit_t le[4] = '{LIM_2, LIM_3, LIM_4, LIM_1};
        logic [1:0] c;
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            wr(0, {1'b1, c[0], 3'b100}, {c[0], c, c, c[1], c, c[0]});
            check("lamp", 32'(discharge_lamp_profile[c[0]]), 32'(c[0]));
            check("cool", 32'(cooling_speed[c[0]]), 32'(ce[k]));
            check("inrush", 32'(inrush_speed[c[0]]), 32'(ie[k]));
            check("hi_lvl", 32'(high_inrush_level_sel[c[0]]), 32'(c[1]));
            check("limit", 32'(steady_limit[c[0]]), 32'(le[k]));
            check("mode", 32'(overcurrent_mode_sel[c[0]]), 32'(c[0]));
        end
        $display("test overcurrent config done");
    endtask
    task automatic t_global;
        logic [8:0] d[5] = '{9'h000, 9'h0b9, 9'h0dc, 9'h050, 9'h134};
        logic [3:0] e[5] = '{4'b0000, 4'b1101, 4'b1010, 4'b0000, 4'b0000};
        sense_t s[5] = '{SENSE_OFF, SENSE_CUR_HS0, SENSE_CUR_HS1, SENSE_OFF, SENSE_TEMP};
        for (int k = 0; k < 5; k++) begin
            wr(0, 5'b00101, d[k]);
            check("pwm", 32'(pwm_drive_outputs), 32'(e[k][3]));
            check("clk_ext", 32'(pwm_clk_external), 32'(e[k][2]));
            check("clk_int", 32'(pwm_clk_internal), 32'(e[k][1]));
            check("sense", 32'(analog_sense_mode), 32'(s[k]));
            check("ov", 32'(overvoltage_prot_off), 32'(e[k][0]));
            check("fs", 32'(failsafe_pwm_drive), 32'h0);
        end
        wr(0, 5'b00111, 9'h1ab);
        check("calib", 32'(clock_calibration_value), 32'h1ab);
        $display("test global config done");
    endtask
    task automatic t_supply;
        int i;
        @(posedge clk);
        #1 supply_fail_pin = 1'b1;
        for (i = 0; i < 20 && failsafe_pwm_drive !== 1'b1; i++) @(posedge clk);
        if (i == 20) begin
            n_mismatch++;
            end_of_test();
        end
        check("fs_on", 32'(failsafe_pwm_drive), 32'h1);
        repeat (2) @(posedge clk);
        check("sense", 32'(analog_sense_mode), 32'(SENSE_OFF));
        check("calib", 32'(clock_calibration_value), 32'h0);
        check("on_ol", 32'(on_openload_en), 32'h3);
        #1 supply_fail_pin = 1'b0;
        repeat (6) @(posedge clk);
        check("fs", 32'(failsafe_pwm_drive), 32'h0);
        $display("test supply fail done");
    endtask
    task automatic t_status;
        logic [31:0] r;
        int n0;
        n0 = n_rearm;
        wr(1, 5'b00000, 9'h01b);
        spi_host_model_inst.xfer(32, {16'hc3a5, 16'h0005}, r);
        check("ret1", r[31:16], {1'b1, 5'b11011, 1'b1, 9'h000});
        check("echo", r[15:0], 16'hc3a5);
        repeat (8) @(posedge clk);
        spi_host_model_inst.xfer(15, 32'h00001480, r);
        repeat (8) @(posedge clk);
        check("pwm", 32'(pwm_drive_outputs), 32'h0);
        spi_host_model_inst.xfer(16, 32'h00008010, r);
        check("ret2", r[15:0], {1'b0, 5'b00101, 1'b1, 9'h100});
        repeat (8) @(posedge clk);
        spi_host_model_inst.xfer(16, 32'h0, r);
        check("ret3", r[15:0], {1'b1, 5'b10000, 1'b1, 9'h0a5});
        repeat (2) @(posedge clk);
        check("rearm", 32'(n_rearm - n0), 32'h5);
        $display("test status return done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_fault();
        t_oc();
        t_global();
        t_supply();
        t_status();
        end_of_test();
    end
endmodule
